// file: design/cmr_pkg.sv
// Constants shared by the comparator control register block
package cmr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] CTRL_IDX = 8'h9a;
   localparam logic [7:0] MODE_IDX = 8'h9c;
   localparam logic [7:0] INSEL_IDX = 8'h9e;
   localparam logic [7:0] INT_STAT_IDX = 8'ha0;
   localparam logic [7:0] INT_MASK_IDX = 8'ha1;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h02;
   localparam logic [7:0] INSEL_RST = 8'h00;
   localparam logic [1:0] INT_MASK_RST = 2'h0;

   // Control register fields
   localparam int CTRL_ON_BIT = 7;
   localparam int CTRL_RESULT_BIT = 6;
   localparam int CTRL_RISE_BIT = 5;
   localparam int CTRL_FALL_BIT = 4;
   localparam int CTRL_PHYST_LSB = 2;
   localparam int CTRL_NHYST_LSB = 0;

   // Mode register fields
   localparam int MODE_RIE_BIT = 5;
   localparam int MODE_FIE_BIT = 4;
   localparam int MODE_RESP_LSB = 0;

   // Input select register fields
   localparam int INSEL_NEG_LSB = 4;
   localparam int INSEL_POS_LSB = 0;
   localparam logic [2:0] INSEL_LAST_CODE = 3'h4;

   // Interrupt status and mask bits
   localparam int INT_RISE_BIT = 0;
   localparam int INT_FALL_BIT = 1;

   // Port pin tables, upper nibble port, lower nibble pin
   localparam logic [7:0] NEG_MAP32 [0:4] = '{8'h13, 8'h17, 8'h23, 8'h27, 8'h05};
   localparam logic [7:0] NEG_MAP48 [0:4] = '{8'h23, 8'h31, 8'h40, 8'h46, 8'h12};
   localparam logic [7:0] POS_MAP32 [0:4] = '{8'h12, 8'h16, 8'h22, 8'h26, 8'h04};
   localparam logic [7:0] POS_MAP48 [0:4] = '{8'h22, 8'h30, 8'h37, 8'h45, 8'h11};

   // AXI4-Lite responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmr_pkg

// file: design/cmr_regs.sv
// Comparator control and status registers behind an AXI4-Lite slave
//
// How it works
// - A rising edge of the comparator result sets the rising-edge event flag.
// - Falling-edge flag stays zero until a falling edge occurs after clearing.
// - Control bits 3:2 select positive hysteresis; code 01 means 5 mV.
// - Control bits 1:0 select negative hysteresis; code 11 means 20 mV.
// - Input select bits 6:4 route one of five pins to negative input.
// - Input select bits 2:0 route one of five pins to positive input.
// - Pin chosen per code depends on package, 32-pin or 48-pin tables.
// - Input select bits 7 and 3 read zero and ignore writes.
// - Mode bits 7:6 and 3:2 read zero and ignore writes.
// - Mode bit 5 enables the rising-edge interrupt at cmpIrq only.
// - Mode bit 4 enables the falling-edge interrupt at cmpIrq only.
// - Mode bits 1:0 pick response time, zero fastest, three lowest power.
// - Control bit 7 turns the comparator on.
// - Control bit 6 reads back the current comparator result.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module cmr_regs
   import cmr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter bit PKG_48 = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cmpResult,
   output logic cmpOn,
   output logic [1:0] posHystSel,
   output logic [1:0] negHystSel,
   output logic [2:0] negInputSel,
   output logic [2:0] posInputSel,
   output logic [7:0] negPin,
   output logic negPinValid,
   output logic [7:0] posPin,
   output logic posPinValid,
   output logic [1:0] responseModeSel,
   output logic cmpIrq,
   output logic intr
);
   import cmr_pkg::*;

   function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction : isReg

   // Write channel state
   logic awHeld_q;
   logic awHeld_d;
   logic [ADDR_W-1:0] awAddr_q;
   logic wHeld_q;
   logic wHeld_d;
   logic [7:0] wData_q;
   logic wLane_q;
   logic bValid_q;
   logic bValid_d;
   logic [1:0] bResp_q;
   logic awReady_q;
   logic wReady_q;
   logic doWrite;
   logic wrHit;

   // Read channel state
   logic arReady_q;
   logic rValid_q;
   logic rValid_d;
   logic [31:0] rData_q;
   logic [1:0] rResp_q;
   logic [7:0] rdMux;
   logic rdHit;

   // Register contents
   logic cmpOn_q;
   logic riseFlag_q;
   logic fallFlag_q;
   logic [1:0] posHyst_q;
   logic [1:0] negHyst_q;
   logic [2:0] negSel_q;
   logic [2:0] posSel_q;
   logic riseIrqEn_q;
   logic fallIrqEn_q;
   logic [1:0] respMode_q;
   logic [1:0] intStat_q;
   logic [1:0] intMask_q;
   logic cmpIrq_q;
   logic intr_q;
   logic [7:0] negPin_q;
   logic [7:0] posPin_q;
   logic negPinValid_q;
   logic posPinValid_q;

   // Comparator result synchroniser and edge detect
   logic resMeta_q;
   logic resSync_q;
   logic resPrev_q;
   logic riseEdge;
   logic fallEdge;

   logic wrCtrl;
   logic wrMode;
   logic wrInsel;
   logic wrStat;
   logic wrMask;

   // Write handshake: address and data are taken in either order
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;

   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      bValid_d = bValid_q;
      if (s_axi_awvalid && awReady_q) begin
         awHeld_d = 1'b1;
      end
      if (s_axi_wvalid && wReady_q) begin
         wHeld_d = 1'b1;
      end
      if (doWrite) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bValid_d = 1'b1;
      end else if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         bValid_q <= 1'b0;
         awReady_q <= 1'b0;
         wReady_q <= 1'b0;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         bValid_q <= bValid_d;
         // Ready stays low while the response waits, so no new write slips in
         awReady_q <= !awHeld_d && !bValid_d;
         wReady_q <= !wHeld_d && !bValid_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         awAddr_q <= '0;
         wData_q <= 8'h00;
         wLane_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awReady_q) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wReady_q) begin
            wData_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            bResp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign wrHit = isReg(awAddr_q, CTRL_IDX) || isReg(awAddr_q, MODE_IDX)
      || isReg(awAddr_q, INSEL_IDX) || isReg(awAddr_q, INT_STAT_IDX)
      || isReg(awAddr_q, INT_MASK_IDX);

   // Only byte lane 0 carries register data; other lanes are ignored
   assign wrCtrl = doWrite && wLane_q && isReg(awAddr_q, CTRL_IDX);
   assign wrMode = doWrite && wLane_q && isReg(awAddr_q, MODE_IDX);
   assign wrInsel = doWrite && wLane_q && isReg(awAddr_q, INSEL_IDX);
   assign wrStat = doWrite && wLane_q && isReg(awAddr_q, INT_STAT_IDX);
   assign wrMask = doWrite && wLane_q && isReg(awAddr_q, INT_MASK_IDX);

   // Read path
   always_comb begin
      rdMux = 8'h00;
      rdHit = 1'b1;
      if (isReg(s_axi_araddr, CTRL_IDX)) begin
         rdMux = {cmpOn_q, resSync_q, riseFlag_q, fallFlag_q, posHyst_q, negHyst_q};
      end else if (isReg(s_axi_araddr, MODE_IDX)) begin
         rdMux = {2'b00, riseIrqEn_q, fallIrqEn_q, 2'b00, respMode_q};
      end else if (isReg(s_axi_araddr, INSEL_IDX)) begin
         rdMux = {1'b0, negSel_q, 1'b0, posSel_q};
      end else if (isReg(s_axi_araddr, INT_STAT_IDX)) begin
         rdMux = {6'h00, intStat_q};
      end else if (isReg(s_axi_araddr, INT_MASK_IDX)) begin
         rdMux = {6'h00, intMask_q};
      end else begin
         rdHit = 1'b0;
      end
   end

   always_comb begin
      rValid_d = rValid_q;
      if (s_axi_arvalid && arReady_q) begin
         rValid_d = 1'b1;
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rValid_q <= 1'b0;
         arReady_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= RESP_OKAY;
      end else begin
         rValid_q <= rValid_d;
         arReady_q <= !rValid_d;
         if (s_axi_arvalid && arReady_q) begin
            rData_q <= {24'h00_0000, rdMux};
            rResp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Two flops before any logic looks at the analog result
   always_ff @(posedge clk) begin
      if (srst) begin
         resMeta_q <= 1'b0;
         resSync_q <= 1'b0;
         resPrev_q <= 1'b0;
      end else begin
         resMeta_q <= cmpResult;
         resSync_q <= resMeta_q;
         resPrev_q <= resSync_q;
      end
   end

   assign riseEdge = resSync_q && !resPrev_q;
   assign fallEdge = !resSync_q && resPrev_q;

   // Control register; an edge in the clearing cycle keeps its flag set
   always_ff @(posedge clk) begin
      if (srst) begin
         cmpOn_q <= CTRL_RST[CTRL_ON_BIT];
         riseFlag_q <= CTRL_RST[CTRL_RISE_BIT];
         fallFlag_q <= CTRL_RST[CTRL_FALL_BIT];
         posHyst_q <= CTRL_RST[CTRL_PHYST_LSB +: 2];
         negHyst_q <= CTRL_RST[CTRL_NHYST_LSB +: 2];
      end else begin
         if (wrCtrl) begin
            cmpOn_q <= wData_q[CTRL_ON_BIT];
            posHyst_q <= wData_q[CTRL_PHYST_LSB +: 2];
            negHyst_q <= wData_q[CTRL_NHYST_LSB +: 2];
         end
         if (riseEdge) begin
            riseFlag_q <= 1'b1;
         end else if (wrCtrl && !wData_q[CTRL_RISE_BIT]) begin
            riseFlag_q <= 1'b0;
         end
         if (fallEdge) begin
            fallFlag_q <= 1'b1;
         end else if (wrCtrl && !wData_q[CTRL_FALL_BIT]) begin
            fallFlag_q <= 1'b0;
         end
      end
   end

   // Mode register; unused bits are simply not stored
   always_ff @(posedge clk) begin
      if (srst) begin
         riseIrqEn_q <= MODE_RST[MODE_RIE_BIT];
         fallIrqEn_q <= MODE_RST[MODE_FIE_BIT];
         respMode_q <= MODE_RST[MODE_RESP_LSB +: 2];
      end else if (wrMode) begin
         riseIrqEn_q <= wData_q[MODE_RIE_BIT];
         fallIrqEn_q <= wData_q[MODE_FIE_BIT];
         respMode_q <= wData_q[MODE_RESP_LSB +: 2];
      end
   end

   // Input select register
   always_ff @(posedge clk) begin
      if (srst) begin
         negSel_q <= INSEL_RST[INSEL_NEG_LSB +: 3];
         posSel_q <= INSEL_RST[INSEL_POS_LSB +: 3];
      end else if (wrInsel) begin
         negSel_q <= wData_q[INSEL_NEG_LSB +: 3];
         posSel_q <= wData_q[INSEL_POS_LSB +: 3];
      end
   end

   // Pin lookup; codes above four route no pin
   always_ff @(posedge clk) begin
      if (srst) begin
         negPin_q <= 8'h00;
         posPin_q <= 8'h00;
         negPinValid_q <= 1'b0;
         posPinValid_q <= 1'b0;
      end else begin
         negPinValid_q <= negSel_q <= INSEL_LAST_CODE;
         posPinValid_q <= posSel_q <= INSEL_LAST_CODE;
         if (negSel_q <= INSEL_LAST_CODE) begin
            negPin_q <= PKG_48 ? NEG_MAP48[negSel_q] : NEG_MAP32[negSel_q];
         end else begin
            negPin_q <= 8'h00;
         end
         if (posSel_q <= INSEL_LAST_CODE) begin
            posPin_q <= PKG_48 ? POS_MAP48[posSel_q] : POS_MAP32[posSel_q];
         end else begin
            posPin_q <= 8'h00;
         end
      end
   end

   // Sticky interrupt status, write one to clear, set beats clear
   always_ff @(posedge clk) begin
      if (srst) begin
         intStat_q <= 2'h0;
         intMask_q <= INT_MASK_RST;
      end else begin
         if (wrMask) begin
            intMask_q <= wData_q[1:0];
         end
         if (riseEdge) begin
            intStat_q[INT_RISE_BIT] <= 1'b1;
         end else if (wrStat && wData_q[INT_RISE_BIT]) begin
            intStat_q[INT_RISE_BIT] <= 1'b0;
         end
         if (fallEdge) begin
            intStat_q[INT_FALL_BIT] <= 1'b1;
         end else if (wrStat && wData_q[INT_FALL_BIT]) begin
            intStat_q[INT_FALL_BIT] <= 1'b0;
         end
      end
   end

   // Both requests lag their cause by one cycle so the outputs stay flops
   always_ff @(posedge clk) begin
      if (srst) begin
         cmpIrq_q <= 1'b0;
         intr_q <= 1'b0;
      end else begin
         cmpIrq_q <= (riseFlag_q && riseIrqEn_q) || (fallFlag_q && fallIrqEn_q);
         intr_q <= |(intStat_q & intMask_q);
      end
   end

   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign cmpOn = cmpOn_q;
   assign posHystSel = posHyst_q;
   assign negHystSel = negHyst_q;
   assign negInputSel = negSel_q;
   assign posInputSel = posSel_q;
   assign negPin = negPin_q;
   assign posPin = posPin_q;
   assign negPinValid = negPinValid_q;
   assign posPinValid = posPinValid_q;
   assign responseModeSel = respMode_q;
   assign cmpIrq = cmpIrq_q;
   assign intr = intr_q;

endmodule : cmr_regs

`default_nettype wire

// file: verif/cmr_cmp_model.sv
// Behavioural model of the analog comparator core on the far side
`timescale 1ns/1ps
`default_nettype none
module cmr_cmp_model (
   input wire logic clk,
   input wire logic cmpOn,
   input wire logic [1:0] responseModeSel,
   input wire logic target,
   output logic cmpResult
);
   logic [7:0] pipe_q = 8'h0;
   always @(posedge clk) begin
      pipe_q <= {pipe_q[6:0], target};
   end
   // Delays are only illustrative; slower modes answer later
   assign cmpResult = cmpOn & pipe_q[{responseModeSel, 1'b1}];
endmodule : cmr_cmp_model
`default_nettype wire

// file: verif/cmr_regs_asserts.sv
// Port-level assertions for the comparator register block
`timescale 1ns/1ps
`default_nettype none
module cmr_regs_asserts
   import cmr_pkg::*;
#(
   parameter bit PKG_48 = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [2:0] negInputSel,
   input wire logic [2:0] posInputSel,
   input wire logic [7:0] negPin,
   input wire logic negPinValid,
   input wire logic [7:0] posPin,
   input wire logic posPinValid,
   input wire logic cmpIrq,
   input wire logic intr
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
   chk_read_busy: assert property (
      s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
      else $error("read channel misbehaves");
   chk_write_busy: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
   chk_pos_map: assert property (
      !srst && posInputSel <= 3'h4 ##1 $stable(posInputSel) |-> posPinValid &&
      posPin == (PKG_48 ? POS_MAP48[posInputSel] : POS_MAP32[posInputSel]))
      else $error("positive pin wrong");
   chk_neg_map: assert property (
      !srst && negInputSel <= 3'h4 ##1 $stable(negInputSel) |-> negPinValid &&
      negPin == (PKG_48 ? NEG_MAP48[negInputSel] : NEG_MAP32[negInputSel]))
      else $error("negative pin wrong");
   chk_pos_invalid: assert property (
      !srst && posInputSel > 3'h4 ##1 $stable(posInputSel) |-> !posPinValid && posPin == 8'h0)
      else $error("invalid code shows a pin");
   chk_neg_invalid: assert property (
      !srst && negInputSel > 3'h4 ##1 $stable(negInputSel) |-> !negPinValid && negPin == 8'h0)
      else $error("invalid negative code shows a pin");
   chk_reset_quiet: assert property (
      $fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && !cmpIrq && !intr)
      else $error("outputs busy after reset");
endmodule : cmr_regs_asserts
bind cmr_regs cmr_regs_asserts #(.PKG_48(PKG_48)) u_chk (.clk, .srst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .negInputSel, .posInputSel, .negPin,
   .negPinValid, .posPin, .posPinValid, .cmpIrq, .intr);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the comparator register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cmr_pkg::*;
   localparam logic [11:0] A_CTRL = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [11:0] A_MODE = {2'h0, MODE_IDX, 2'h0};
   localparam logic [11:0] A_INSEL = {2'h0, INSEL_IDX, 2'h0};
   localparam logic [11:0] A_STAT = {2'h0, INT_STAT_IDX, 2'h0};
   localparam logic [11:0] A_MASK = {2'h0, INT_MASK_IDX, 2'h0};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, target = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic cmpResult, cmpOn, negPinValid, posPinValid, cmpIrq, intr;
   logic [1:0] s_axi_bresp, s_axi_rresp, posHystSel, negHystSel, responseModeSel;
   logic [2:0] negInputSel, posInputSel;
   logic [7:0] negPin, posPin;
   logic [7:0] negPin48, posPin48;
   logic negPinValid48, posPinValid48;
   logic [31:0] s_axi_rdata;
   int fails = 0;
   int nTests = 0;
   int i;
   always #2.5 clk = ~clk;
   cmr_regs dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .cmpResult, .cmpOn, .posHystSel, .negHystSel,
      .negInputSel, .posInputSel, .negPin, .negPinValid, .posPin, .posPinValid,
      .responseModeSel, .cmpIrq, .intr);
   // Second copy with the larger package tables, fed by the same bus
   cmr_regs #(.PKG_48(1'b1)) dut48 (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
      .cmpResult, .cmpOn(), .posHystSel(), .negHystSel(), .negInputSel(), .posInputSel(),
      .negPin(negPin48), .negPinValid(negPinValid48), .posPin(posPin48),
      .posPinValid(posPinValid48), .responseModeSel(), .cmpIrq(), .intr());
   cmr_cmp_model far_end (.clk, .cmpOn, .responseModeSel, .target, .cmpResult);
   task automatic wrap_up;
      if (fails == 0 && nTests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // Handshakes are judged at the falling edge, so flop updates never race the sample
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta, tw, done;
      logic [1:0] r;
      done = 1'b0;
      r = 2'h3;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int k = 0; k < 40 && !done; k++) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
      end
      if (!done) begin
         fails++;
         wrap_up();
      end
      chk({30'h0, r}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      logic tk, done;
      logic [33:0] r;
      done = 1'b0;
      r = '1;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int k = 0; k < 40 && !done; k++) begin
         @(negedge clk);
         tk = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         r = {s_axi_rresp, s_axi_rdata};
         @(posedge clk);
         if (tk) s_axi_arvalid <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
      if (!done) begin
         fails++;
         wrap_up();
      end
      chk(r[31:0], {24'h0, e});
      chk({30'h0, r[33:32]}, {30'h0, er});
   endtask : rd
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(A_CTRL, CTRL_RST, RESP_OKAY);
      rd(A_MODE, MODE_RST, RESP_OKAY);
      rd(A_INSEL, INSEL_RST, RESP_OKAY);
      rd(A_MASK, 8'h00, RESP_OKAY);
      wr(A_INSEL, 8'hff, RESP_OKAY);
      rd(A_INSEL, 8'h77, RESP_OKAY);
      wr(A_MODE, 8'hff, RESP_OKAY);
      rd(A_MODE, 8'h33, RESP_OKAY);
      wr(12'h004, 8'h5a, RESP_SLVERR);
      rd(12'h004, 8'h00, RESP_SLVERR);
      for (i = 0; i < 4; i++) begin
         wr(A_CTRL, 8'h80 | 8'(i * 5), RESP_OKAY);
         wr(A_MODE, 8'(i), RESP_OKAY);
         wt(2);
         chk(32'({cmpOn, posHystSel, negHystSel, responseModeSel}),
            32'({1'b1, i[1:0], i[1:0], i[1:0]}));
      end
      for (i = 0; i < 6; i++) begin
         wr(A_INSEL, {1'b0, i[2:0], 1'b0, i[2:0]}, RESP_OKAY);
         wt(2);
         if (i < 5) begin
            chk(32'({negPinValid, negPin, posPinValid, posPin}),
               32'({1'b1, NEG_MAP32[i], 1'b1, POS_MAP32[i]}));
            chk(32'({negPinValid48, negPin48, posPinValid48, posPin48}),
               32'({1'b1, NEG_MAP48[i], 1'b1, POS_MAP48[i]}));
         end else begin
            chk(32'({negPinValid, negPin, posPinValid, posPin}), 32'h0);
            chk(32'({negPinValid48, negPin48, posPinValid48, posPin48}), 32'h0);
         end
      end
      wr(A_CTRL, 8'h80, RESP_OKAY);
      wr(A_MODE, 8'h20, RESP_OKAY);
      wr(A_MASK, 8'h01, RESP_OKAY);
      target <= 1'b1;
      wt(12);
      chk(32'({cmpIrq, intr}), 32'h3);
      rd(A_CTRL, 8'he0, RESP_OKAY);
      wr(A_MODE, 8'h00, RESP_OKAY);
      wt(2);
      chk(32'(cmpIrq), 32'h0);
      target <= 1'b0;
      wt(12);
      rd(A_CTRL, 8'hb0, RESP_OKAY);
      wr(A_CTRL, 8'h90, RESP_OKAY);
      wt(2);
      chk(32'({cmpIrq, intr}), 32'h1);
      rd(A_CTRL, 8'h90, RESP_OKAY);
      wr(A_MODE, 8'h10, RESP_OKAY);
      wt(2);
      chk(32'(cmpIrq), 32'h1);
      rd(A_STAT, 8'h03, RESP_OKAY);
      wr(A_STAT, 8'h01, RESP_OKAY);
      rd(A_STAT, 8'h02, RESP_OKAY);
      wt(2);
      chk(32'(intr), 32'h0);
      wr(A_MASK, 8'h03, RESP_OKAY);
      wt(2);
      chk(32'(intr), 32'h1);
      wr(A_STAT, 8'h02, RESP_OKAY);
      wt(2);
      chk(32'(intr), 32'h0);
      wr(A_CTRL, 8'h80, RESP_OKAY);
      rd(A_CTRL, 8'h80, RESP_OKAY);
      // A write with lane 0 switched off must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(A_MASK, 8'h00, RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rd(A_MASK, 8'h03, RESP_OKAY);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
